/* hdl/vrc_ctrl.sv */
// Host-side strobe sequencer for a dual-port video memory random port.
// Assumes memory pins are sampled by the memory on strobe edges; dq input synchronous.
//
// Operation
// R1: Host refreshes every row at least once each 8 ms.
// R2: Row-strobe-only refresh: host supplies the row; column strobe stays high.
// R3: Column strobe falling before row strobe makes the device refresh internally.
// R4: Device refresh counter survives other cycles between its refreshes.
// R5: Hidden refresh: keep column strobe low after read, cycle row strobe.
// R6: Write strobe low at row fall enables masked write; high writes all lines.
// R7: Select low at row fall of masked write reloads mask from data lines.
// R8: Mask bit one writes its line, zero blocks it.
// R9: Write data latched on later of column or write strobe fall.
// R10: Select high at row fall keeps the last loaded mask.
// R11: Colour load: select high at both falls, value on data lines.
// R12: Block write: select high at column fall, write strobe low.
// R13: Block write latches A2-A8; data lines carry the column mask.
// R14: Column mask bit one enables its column; at most 16 bits per cycle.
// R15: Device combines write mask with column mask in block writes.
// R16: Transfer: gate low before row fall; write, shift gate, select pick type.
// R17: Decode: normal write, alternate write, normal read, split read.
// R18: Write, select low, shift gate high: pseudo transfer, serial port to input.
// R19: Write transfers copy buffer to row; all leave serial port input.
// R20: Write transfer row from row fall, tap point from column fall.
// R21: Host pauses serial input clocking around a write transfer.
// R22: Every split read transfer supplies a fresh tap point.
// R23: Device keeps data lines floating through any transfer cycle.
// R24: After read transfer serial port outputs, addressed modulo 512.
// R25: Power-up: 200 us wait, eight refreshes, one read transfer, two shift clocks.
// R26: Device refresh counter steps by one and wraps over 512 rows.
// R27: Host loads mask and colour before relying on them.
`timescale 1ns/1ps
`include "vrc_defs.svh"

module vrc_ctrl #(
  parameter logic [15:0] INIT_CYCLES = 16'(`VRC_INIT_CYC)
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire vrc_pkg::vrc_cmd_s cmd,
  output logic rd_valid,
  output logic [3:0] rd_data,
  output logic init_done,
  output vrc_pkg::vrc_pins_s pins,
  input wire logic [3:0] random_io_in
);

  localparam logic [3:0] PH_LAST = 4'(`VRC_PHASE_CYC - 1);
  localparam logic [11:0] REF_LAST = 12'(`VRC_REF_CYC - 1);
  localparam logic [3:0] CBR_N = 4'(`VRC_INIT_CBR);
  localparam logic [1:0] SC_N = 2'(`VRC_INIT_SC);

  vrc_pkg::vrc_state_s s_ff;
  vrc_pkg::vrc_state_s nxt_s;

  // Pin levels for a given state and command
  function automatic vrc_pkg::vrc_pins_s pins_for(input vrc_pkg::vrc_st_e st,
                                                  input vrc_pkg::vrc_cmd_s c);
    vrc_pkg::vrc_pins_s p;
    logic is_rd;
    logic is_xfer;
    logic ras_we;
    logic ras_dsf;
    logic col_we;
    logic cas_dsf;
    logic blk;
    // Idle levels; shift clock pulses only in warm-up, never around a write transfer [R21]
    p = '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, output_gate_n: 1'b1,
          special_function_select: 1'b0, shift_port_gate_n: 1'b0, shift_clock: 1'b0,
          addr: 9'h000, random_io_out: 4'h0, random_io_oe_n: 1'b1};
    is_rd = (c.op == vrc_pkg::OP_READ) || (c.op == vrc_pkg::OP_READ_HIDDEN);
    is_xfer = (c.op == vrc_pkg::OP_XFER_READ) || (c.op == vrc_pkg::OP_XFER_SPLIT) ||
              (c.op == vrc_pkg::OP_XFER_WRITE) || (c.op == vrc_pkg::OP_XFER_ALT) ||
              (c.op == vrc_pkg::OP_XFER_PSEUDO);
    blk = (c.op == vrc_pkg::OP_BLOCK);
    // Write strobe at row fall: masked writes and write-type transfers [R6] [R16]
    ras_we = (((c.op == vrc_pkg::OP_WRITE) || blk) && (c.wmode != vrc_pkg::WM_NONE)) ||
             (c.op == vrc_pkg::OP_XFER_WRITE) || (c.op == vrc_pkg::OP_XFER_ALT) ||
             (c.op == vrc_pkg::OP_XFER_PSEUDO);
    // Select at row fall: persistent mask, mask/colour load, split, alternate [R10] [R17]
    ras_dsf = (((c.op == vrc_pkg::OP_WRITE) || blk) && (c.wmode == vrc_pkg::WM_PERSIST)) ||
              (c.op == vrc_pkg::OP_LOAD_MASK) || (c.op == vrc_pkg::OP_LOAD_COLOR) ||
              (c.op == vrc_pkg::OP_XFER_SPLIT) || (c.op == vrc_pkg::OP_XFER_ALT);
    col_we = (c.op == vrc_pkg::OP_WRITE) || blk || (c.op == vrc_pkg::OP_LOAD_MASK) ||
             (c.op == vrc_pkg::OP_LOAD_COLOR);
    cas_dsf = blk || (c.op == vrc_pkg::OP_LOAD_COLOR); // [R11] [R12]
    case (st)
      vrc_pkg::S_RAS_SET, vrc_pkg::S_RAS_LOW: begin
        p.addr = c.row; // [R2] [R20]
        p.we_n = ~ras_we;
        p.special_function_select = ras_dsf;
        p.output_gate_n = ~is_xfer; // [R16]
        p.shift_port_gate_n = (c.op == vrc_pkg::OP_XFER_PSEUDO); // [R18]
        // Mask reload presented on the data lines at row fall [R7] [R8]
        p.random_io_out = c.wmask;
        p.random_io_oe_n = ~(ras_we && !is_xfer && !ras_dsf);
        p.ras_n = (st == vrc_pkg::S_RAS_SET);
      end
      vrc_pkg::S_COL_SET, vrc_pkg::S_CAS_LOW: begin
        p.ras_n = 1'b0;
        // Block writes drive only A2-A8 meaningfully [R13]
        p.addr = blk ? {c.col[8:2], 2'b00} : c.col; // [R20] [R22]
        p.special_function_select = cas_dsf;
        p.we_n = ~col_we; // [R9]
        p.output_gate_n = ~is_rd;
        // Column mask for block, mask for mask load, else data or colour [R14] [R15]
        p.random_io_out = blk ? c.cmask :
                          (c.op == vrc_pkg::OP_LOAD_MASK) ? c.wmask : c.data;
        p.random_io_oe_n = ~col_we;
        p.cas_n = (st == vrc_pkg::S_COL_SET);
      end
      vrc_pkg::S_HID_UP, vrc_pkg::S_HID_DN: begin
        // Column strobe and gate stay low so read data remains valid [R5]
        p.cas_n = 1'b0;
        p.output_gate_n = 1'b0;
        p.ras_n = (st == vrc_pkg::S_HID_UP);
      end
      vrc_pkg::S_CBR_CAS: p.cas_n = 1'b0; // [R3]
      vrc_pkg::S_CBR_RAS: begin
        p.cas_n = 1'b0;
        p.ras_n = 1'b0;
      end
      vrc_pkg::S_SC_HI: p.shift_clock = 1'b1; // [R25]
      default: p.ras_n = 1'b1;
    endcase
    return p;
  endfunction : pins_for

  // Next-state logic: init, refresh arbitration, strobe sequencing
  always_comb begin
    logic done;
    logic tick;
    logic ref_clr;
    nxt_s = s_ff;
    nxt_s.rd_valid = 1'b0;
    done = (s_ff.step == PH_LAST);
    nxt_s.step = done ? 4'h0 : 4'(s_ff.step + 4'h1);
    // Per-row refresh spacing timer [R1]
    tick = (s_ff.ref_cnt == REF_LAST);
    nxt_s.ref_cnt = tick ? 12'h000 : 12'(s_ff.ref_cnt + 12'h001);
    ref_clr = 1'b0;
    case (s_ff.st)
      vrc_pkg::S_INIT_WAIT: begin
        nxt_s.step = 4'h0;
        if (s_ff.init_cnt == 16'(INIT_CYCLES - 16'h0001)) begin
          nxt_s.st = vrc_pkg::S_IDLE; // [R25]
        end else begin
          nxt_s.init_cnt = 16'(s_ff.init_cnt + 16'h0001);
        end
      end
      vrc_pkg::S_IDLE: begin
        nxt_s.step = 4'h0;
        if (!s_ff.init_done) begin
          // Warm-up: refreshes, one read transfer, shift clocks [R25]
          if (s_ff.cbr_cnt != CBR_N) begin
            nxt_s.cbr_cnt = 4'(s_ff.cbr_cnt + 4'h1);
            nxt_s.cmd.op = vrc_pkg::OP_REFRESH_CBR;
            nxt_s.st = vrc_pkg::S_CBR_CAS;
            ref_clr = 1'b1;
          end else if (!s_ff.xfer_done) begin
            nxt_s.xfer_done = 1'b1;
            nxt_s.cmd = '{op: vrc_pkg::OP_XFER_READ, wmode: vrc_pkg::WM_NONE,
                          row: 9'h000, col: 9'h000, data: 4'h0, wmask: 4'h0, cmask: 4'h0};
            nxt_s.st = vrc_pkg::S_RAS_SET;
          end else if (s_ff.sc_cnt != SC_N) begin
            nxt_s.sc_cnt = 2'(s_ff.sc_cnt + 2'h1);
            nxt_s.st = vrc_pkg::S_SC_HI;
          end else begin
            nxt_s.init_done = 1'b1;
          end
        end else if (s_ff.ref_pend) begin
          // Periodic internal refresh ahead of user work [R1] [R3] [R4]
          nxt_s.cmd.op = vrc_pkg::OP_REFRESH_CBR;
          nxt_s.st = vrc_pkg::S_CBR_CAS;
          ref_clr = 1'b1;
        end else if (cmd_valid) begin
          nxt_s.cmd = cmd;
          nxt_s.st = (cmd.op == vrc_pkg::OP_REFRESH_CBR) ? vrc_pkg::S_CBR_CAS :
                     vrc_pkg::S_RAS_SET;
        end
      end
      vrc_pkg::S_RAS_SET: if (done) nxt_s.st = vrc_pkg::S_RAS_LOW;
      vrc_pkg::S_RAS_LOW: begin
        if (done) begin
          // Row-only refresh never lowers the column strobe [R2]
          nxt_s.st = (s_ff.cmd.op == vrc_pkg::OP_REFRESH_ROW) ? vrc_pkg::S_PRE :
                     vrc_pkg::S_COL_SET;
        end
      end
      vrc_pkg::S_COL_SET: if (done) nxt_s.st = vrc_pkg::S_CAS_LOW;
      vrc_pkg::S_CAS_LOW: begin
        if (done) begin
          if ((s_ff.cmd.op == vrc_pkg::OP_READ) || (s_ff.cmd.op == vrc_pkg::OP_READ_HIDDEN)) begin
            nxt_s.rd_valid = 1'b1;
            nxt_s.rd_data = random_io_in;
          end
          nxt_s.st = (s_ff.cmd.op == vrc_pkg::OP_READ_HIDDEN) ? vrc_pkg::S_HID_UP :
                     vrc_pkg::S_PRE; // [R5]
        end
      end
      vrc_pkg::S_HID_UP: if (done) nxt_s.st = vrc_pkg::S_HID_DN;
      vrc_pkg::S_HID_DN: if (done) nxt_s.st = vrc_pkg::S_PRE;
      vrc_pkg::S_CBR_CAS: if (done) nxt_s.st = vrc_pkg::S_CBR_RAS;
      vrc_pkg::S_CBR_RAS: if (done) nxt_s.st = vrc_pkg::S_PRE;
      vrc_pkg::S_SC_HI: if (done) nxt_s.st = vrc_pkg::S_SC_LO;
      vrc_pkg::S_SC_LO: if (done) nxt_s.st = vrc_pkg::S_IDLE;
      vrc_pkg::S_PRE: if (done) nxt_s.st = vrc_pkg::S_IDLE;
      default: nxt_s.st = vrc_pkg::S_IDLE;
    endcase
    // New tick wins over a clear in the same cycle
    nxt_s.ref_pend = (s_ff.ref_pend & ~ref_clr) | tick;
    nxt_s.pins = pins_for(nxt_s.st, nxt_s.cmd);
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
      s_ff.pins.ras_n <= 1'b1;
      s_ff.pins.cas_n <= 1'b1;
      s_ff.pins.we_n <= 1'b1;
      s_ff.pins.output_gate_n <= 1'b1;
      s_ff.pins.random_io_oe_n <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // User-side outputs
  assign cmd_ready = (s_ff.st == vrc_pkg::S_IDLE) && s_ff.init_done && !s_ff.ref_pend;
  assign rd_valid = s_ff.rd_valid;
  assign rd_data = s_ff.rd_data;
  assign init_done = s_ff.init_done;
  assign pins = s_ff.pins;

endmodule : vrc_ctrl

/* hdl/vrc_defs.svh */
// Timing and sequencing constants for the video memory strobe controller.
// Assumes a single system clock; all cycle counts are derived from its period.
`ifndef VRC_DEFS_SVH
`define VRC_DEFS_SVH

// System clock period
`define VRC_CLK_NS 5
// Length of one strobe phase, rounded up to whole cycles
`define VRC_PHASE_NS 40
`define VRC_PHASE_CYC ((`VRC_PHASE_NS + `VRC_CLK_NS - 1) / `VRC_CLK_NS)
// Whole-array refresh period and row count; per-row spacing rounds down
`define VRC_REF_PERIOD_NS 8000000
`define VRC_ROWS 512
`define VRC_REF_CYC (`VRC_REF_PERIOD_NS / `VRC_ROWS / `VRC_CLK_NS)
// Power-up pause, then warm-up refreshes and shift clocks
`define VRC_INIT_US 200
`define VRC_INIT_CYC (`VRC_INIT_US * 1000 / `VRC_CLK_NS)
`define VRC_INIT_CBR 8
`define VRC_INIT_SC 2

`endif

/* hdl/vrc_pkg.sv */
// Types for the video memory strobe controller.
// Assumes nothing beyond a SystemVerilog compiler.
package vrc_pkg;

  // User operations
  typedef enum logic [3:0] {
    OP_READ, OP_READ_HIDDEN, OP_WRITE, OP_BLOCK, OP_LOAD_MASK, OP_LOAD_COLOR,
    OP_REFRESH_ROW, OP_REFRESH_CBR, OP_XFER_READ, OP_XFER_SPLIT, OP_XFER_WRITE,
    OP_XFER_ALT, OP_XFER_PSEUDO
  } vrc_op_e;

  // Write mask mode of a write or block write
  typedef enum logic [1:0] {
    WM_NONE, WM_RELOAD, WM_PERSIST
  } vrc_wmode_e;

  // Sequencer states
  typedef enum logic [3:0] {
    S_INIT_WAIT, S_IDLE, S_RAS_SET, S_RAS_LOW, S_COL_SET, S_CAS_LOW,
    S_HID_UP, S_HID_DN, S_CBR_CAS, S_CBR_RAS, S_PRE, S_SC_HI, S_SC_LO
  } vrc_st_e;

  // One user command
  typedef struct packed {
    vrc_op_e op;
    vrc_wmode_e wmode;
    logic [8:0] row;
    logic [8:0] col;
    logic [3:0] data;
    logic [3:0] wmask;
    logic [3:0] cmask;
  } vrc_cmd_s;

  // Pins driven toward the memory
  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic output_gate_n;
    logic special_function_select;
    logic shift_port_gate_n;
    logic shift_clock;
    logic [8:0] addr;
    logic [3:0] random_io_out;
    logic random_io_oe_n;
  } vrc_pins_s;

  // Whole controller state
  typedef struct packed {
    vrc_st_e st;
    logic [3:0] step;
    vrc_cmd_s cmd;
    vrc_pins_s pins;
    logic [11:0] ref_cnt;
    logic ref_pend;
    logic [15:0] init_cnt;
    logic [3:0] cbr_cnt;
    logic xfer_done;
    logic [1:0] sc_cnt;
    logic init_done;
    logic rd_valid;
    logic [3:0] rd_data;
  } vrc_state_s;

endpackage : vrc_pkg

/* tb/vrc_mem_model.sv */
// Strobe-level model of the video memory random port.
// Assumes the controller pin struct; undriven data lines show the inverse value.
`timescale 1ns/1ps
module vrc_mem_model (
  input wire vrc_pkg::vrc_pins_s pins,
  output logic [3:0] random_io_in
);
  logic [3:0] mem [int];
  logic [8:0] ref_row = 9'h000;
  logic [8:0] row, col;
  logic [3:0] wmask, colour; // Undefined until loaded
  logic [3:0] rd_val = 4'h0;
  vrc_pkg::vrc_op_e last_kind = vrc_pkg::OP_READ;
  logic column_before_row_refresh = 1'b0;
  logic xfer = 1'b0;
  logic seen = 1'b0;
  logic ser_in = 1'b0;
  logic wpb, dsf_r, done_w;

  // Masked merge into one location
  task automatic put(input int k, input logic [3:0] v, input logic [3:0] m);
    logic [3:0] old;
    old = mem.exists(k) ? mem[k] : 4'h0;
    mem[k] = (old & ~m) | (v & m);
  endtask : put

  // Drive only in a random access with both gates low
  assign random_io_in = (!pins.cas_n && !pins.output_gate_n && !xfer && !column_before_row_refresh) ?
    rd_val : ~rd_val;

  // Row strobe fall: refresh, transfer decode or access setup
  always @(negedge pins.ras_n) begin
    if (!pins.cas_n) begin
      column_before_row_refresh = !seen;
      ref_row = ref_row + 9'h001; // Own row counter, wraps
    end else begin
      {column_before_row_refresh, seen, done_w, row} = {3'b000, pins.addr};
      xfer = !pins.output_gate_n;
      wpb = !pins.we_n;
      dsf_r = pins.special_function_select;
      if (!xfer && wpb && !dsf_r) wmask = pins.random_io_out;
      last_kind = vrc_pkg::OP_REFRESH_ROW;
      if (xfer) begin
        ser_in = wpb;
        if (!wpb) last_kind = dsf_r ? vrc_pkg::OP_XFER_SPLIT : vrc_pkg::OP_XFER_READ;
        else if (dsf_r) last_kind = vrc_pkg::OP_XFER_ALT;
        else last_kind = pins.shift_port_gate_n ? vrc_pkg::OP_XFER_PSEUDO :
          vrc_pkg::OP_XFER_WRITE;
      end
    end
  end

  // Column fall latches column; write on the later of column or write fall
  always @(negedge pins.cas_n or negedge pins.we_n) begin
    if (!pins.ras_n && !pins.cas_n && !column_before_row_refresh && !seen) begin
      seen = 1'b1;
      col = pins.addr; // Tap point in transfers
      rd_val = mem.exists({row, col}) ? mem[{row, col}] : 4'h0;
    end
    if (!pins.ras_n && !pins.cas_n && !pins.we_n && !column_before_row_refresh && !xfer && !done_w) begin
      done_w = 1'b1;
      if (dsf_r && !wpb && pins.special_function_select) colour = pins.random_io_out;
      else if (dsf_r && !wpb) wmask = pins.random_io_out;
      else if (pins.special_function_select) begin
        for (int k = 0; k < 4; k++)
          if (pins.random_io_out[k]) put({row, col[8:2], 2'(k)}, colour, wpb ? wmask : 4'hf);
      end else put({row, col}, pins.random_io_out, wpb ? wmask : 4'hf);
    end
  end

  // Column rise ends an access
  always @(posedge pins.cas_n) seen = 1'b0;
endmodule : vrc_mem_model

/* tb/vrc_ctrl_checker.sv */
// Port assertions for the strobe controller.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/1ps
module vrc_ctrl_checker (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire vrc_pkg::vrc_cmd_s cmd,
  input wire logic rd_valid,
  input wire logic [3:0] rd_data,
  input wire logic init_done,
  input wire vrc_pkg::vrc_pins_s pins,
  input wire logic [3:0] random_io_in
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic t;
  vrc_pkg::vrc_op_e o;
  vrc_pkg::vrc_pins_s p;
  // Command take and shorthands
  assign t = cmd_valid && cmd_ready;
  assign o = cmd.op;
  assign p = pins;

  a_ready_after_warmup: assert property (cmd_ready |-> init_done && p.ras_n && p.cas_n &&
    p.random_io_oe_n)
    else $error("command port open before warm-up");
  a_row_refresh_quiet: assert property (t && o == vrc_pkg::OP_REFRESH_ROW |-> ##9
    ($fell(p.ras_n) && p.cas_n && p.addr == $past(cmd.row, 9)) ##1 p.cas_n [*8])
    else $error("row refresh strobes wrong");
  a_cbr_cas_first: assert property (t && o == vrc_pkg::OP_REFRESH_CBR |->
    ##[1:9] $fell(p.cas_n) ##[1:9] ($fell(p.ras_n) && !p.cas_n))
    else $error("column strobe not before row strobe");
  a_mask_reload_pins: assert property (t && o == vrc_pkg::OP_WRITE &&
    cmd.wmode == vrc_pkg::WM_RELOAD |-> ##9 ($fell(p.ras_n) && !p.we_n &&
    !p.special_function_select && !p.random_io_oe_n && p.random_io_out == $past(cmd.wmask, 9)))
    else $error("mask reload pins wrong");
  a_persist_pins: assert property (t && o == vrc_pkg::OP_WRITE &&
    cmd.wmode == vrc_pkg::WM_PERSIST |-> ##9 ($fell(p.ras_n) && !p.we_n && p.special_function_select))
    else $error("persistent write pins wrong");
  a_block_cas_pins: assert property (t && o == vrc_pkg::OP_BLOCK |-> ##25 ($fell(p.cas_n) &&
    p.special_function_select && !p.we_n && p.addr[1:0] == 2'h0 &&
    p.random_io_out == $past(cmd.cmask, 25)))
    else $error("block write column pins wrong");
  a_xfer_gate_first: assert property ($fell(p.ras_n) && !p.output_gate_n && p.cas_n |->
    !$past(p.output_gate_n) && p.random_io_oe_n)
    else $error("transfer gate late or data driven");
  a_pseudo_decode: assert property (t && o == vrc_pkg::OP_XFER_PSEUDO |-> ##9
    ($fell(p.ras_n) && !p.output_gate_n && !p.we_n && !p.special_function_select &&
    p.shift_port_gate_n))
    else $error("pseudo transfer pins wrong");
endmodule : vrc_ctrl_checker

bind vrc_ctrl vrc_ctrl_checker chk_u (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd(cmd), .rd_valid(rd_valid), .rd_data(rd_data),
  .init_done(init_done), .pins(pins), .random_io_in(random_io_in));

/* tb/tb.sv */
// Self-checking bench: controller against the strobe-level memory model.
// Assumes model and checker files are compiled first.
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  vrc_pkg::vrc_cmd_s cmd = '0;
  logic cmd_ready, rd_valid, init_done;
  logic [3:0] rd_data, random_io_in;
  vrc_pkg::vrc_pins_s pins;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int wait_n = 0;
  always #2.5 clk_sys = ~clk_sys;

  vrc_ctrl #(.INIT_CYCLES(16'h0010)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .rd_valid(rd_valid),
    .rd_data(rd_data), .init_done(init_done), .pins(pins), .random_io_in(random_io_in));
  vrc_mem_model mdl_u (.pins(pins), .random_io_in(random_io_in));

  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  // Compare and count
  task automatic chk(input string nm, input logic [4:0] e, input logic [4:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One command: rc is row and column, dmc is data, mask, column mask
  task automatic run(input vrc_pkg::vrc_op_e op, input logic [17:0] rc, input logic [11:0] dmc,
      input logic [4:0] e, input vrc_pkg::vrc_wmode_e wm = vrc_pkg::WM_NONE);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd <= '{op, wm, rc[17:9], rc[8:0], dmc[11:8], dmc[7:4], dmc[3:0]};
    do @(posedge clk_sys); while (cmd_ready !== 1'b1 && ++n < 900);
    cmd_valid <= 1'b0;
    if (op inside {vrc_pkg::OP_READ, vrc_pkg::OP_READ_HIDDEN}) begin
      do @(posedge clk_sys); while (rd_valid !== 1'b1 && ++n < 900);
      chk("read data", e, {1'b0, rd_data});
    end
    do @(posedge clk_sys); while (cmd_ready !== 1'b1 && ++n < 900);
    chk("handshake", 5'h01, {4'h0, n < 900});
    if (op == vrc_pkg::OP_LOAD_MASK) chk("mask", e, {1'b0, mdl_u.wmask});
    if (op == vrc_pkg::OP_LOAD_COLOR) chk("colour", e, {1'b0, mdl_u.colour});
    if (op >= vrc_pkg::OP_XFER_READ || op == vrc_pkg::OP_REFRESH_ROW)
      chk("cycle kind", {e[4], op}, {mdl_u.ser_in, mdl_u.last_kind});
  endtask : run

  // Cycle ceiling against hangs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      test_done();
    end
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    while (init_done !== 1'b1) @(posedge clk_sys);
    chk("warm-up refreshes", 5'h01, {4'h0, mdl_u.ref_row >= 9'h008});
    chk("warm-up transfer", {1'b0, vrc_pkg::OP_XFER_READ}, {mdl_u.ser_in, mdl_u.last_kind});
    run(vrc_pkg::OP_LOAD_MASK, 18'h00000, 12'h050, 5'h05);
    run(vrc_pkg::OP_LOAD_COLOR, 18'h00000, 12'h600, 5'h06);
    run(vrc_pkg::OP_WRITE, 18'h00203, 12'ha00, 5'h00);
    run(vrc_pkg::OP_READ, 18'h00203, 12'h000, 5'h0a);
    run(vrc_pkg::OP_WRITE, 18'h00203, 12'hf00, 5'h00, vrc_pkg::WM_PERSIST);
    run(vrc_pkg::OP_READ, 18'h00203, 12'h000, 5'h0f);
    run(vrc_pkg::OP_WRITE, 18'h00203, 12'h030, 5'h00, vrc_pkg::WM_RELOAD);
    run(vrc_pkg::OP_READ_HIDDEN, 18'h00203, 12'h000, 5'h0c);
    run(vrc_pkg::OP_WRITE, 18'h0050e, 12'h900, 5'h00);
    run(vrc_pkg::OP_BLOCK, 18'h0050f, 12'h00b, 5'h00);
    run(vrc_pkg::OP_READ, 18'h0050c, 12'h000, 5'h06);
    run(vrc_pkg::OP_READ, 18'h0050e, 12'h000, 5'h09);
    run(vrc_pkg::OP_BLOCK, 18'h0050c, 12'h024, 5'h00, vrc_pkg::WM_RELOAD);
    run(vrc_pkg::OP_READ, 18'h0050e, 12'h000, 5'h0b);
    run(vrc_pkg::OP_XFER_WRITE, 18'h00a05, 12'h000, 5'h10);
    chk("write row", 5'h01, {4'h0, mdl_u.row == 9'h005});
    run(vrc_pkg::OP_XFER_READ, 18'h00a05, 12'h000, 5'h00);
    run(vrc_pkg::OP_XFER_ALT, 18'h00c07, 12'h000, 5'h10);
    run(vrc_pkg::OP_XFER_SPLIT, 18'h00d10, 12'h000, 5'h00);
    chk("split tap", 5'h01, {4'h0, mdl_u.col == 9'h110});
    run(vrc_pkg::OP_XFER_PSEUDO, 18'h00000, 12'h000, 5'h10);
    run(vrc_pkg::OP_REFRESH_ROW, 18'h1fe00, 12'h000, 5'h10);
    run(vrc_pkg::OP_REFRESH_CBR, 18'h00000, 12'h000, 5'h00);
    // Eight warm-up, one hidden, one user refresh, counter undisturbed between
    chk("refresh counter", 5'h01, {4'h0, mdl_u.ref_row == 9'h00a});
    // Periodic refresh must arrive on its own within 3200 cycles, just over one spacing interval
    while (mdl_u.ref_row == 9'h00a && wait_n < 3200) begin
      @(posedge clk_sys);
      wait_n++;
    end
    chk("periodic refresh", 5'h01, {4'h0, mdl_u.ref_row == 9'h00b});
    test_done();
  end
endmodule : tb
